// File: rtl/lcd_segment_common_driver.sv
// Segment/common panel driver with supply, mode register and display memory
module lcd_segment_common_driver #(
   parameter int NUM_SEG = lcd_drv_pkg::NUM_SEG,
   parameter int DIV_BASE = lcd_drv_pkg::DIV_BASE_LOG2
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [15:0] cpu_addr_i,
   input wire logic cpu_wr_i,
   input wire logic cpu_bit_wr_i,
   input wire logic [2:0] cpu_bit_sel_i,
   input wire logic [7:0] cpu_wdata_i,
   output logic [7:0] cpu_rdata_o,
   output logic cpu_hit_o,
   output logic ladder_supply_select_o,
   output logic [2*lcd_drv_pkg::NUM_COM-1:0] common_outputs_o,
   output logic [2*NUM_SEG-1:0] segment_outputs_o,
   output logic [1:0] phase_o,
   output logic polarity_o
);
   initial begin
      if (NUM_SEG < 1 || NUM_SEG > 28) begin
         $error("lcd_segment_common_driver: NUM_SEG out of range");
      end
   end

   // ------------------------------------------------------------
   // Register access
   // ------------------------------------------------------------
   logic [7:0] supply_r;
   logic [7:0] supply_nxt;
   logic [7:0] mode_r;
   logic [7:0] mode_nxt;
   logic [3:0] mem_r [NUM_SEG];
   logic sel_supply_w;
   logic sel_mode_w;
   logic sel_mem_w;
   logic [4:0] mem_idx_w;
   logic [7:0] cur_w;
   logic [7:0] wval_w;
   logic wr_any_w;

   assign sel_supply_w = cpu_addr_i == lcd_drv_pkg::SUPPLY_ADDR;
   assign sel_mode_w = cpu_addr_i == lcd_drv_pkg::MODE_ADDR;
   assign sel_mem_w = cpu_addr_i >= lcd_drv_pkg::MEM_FIRST &&
      cpu_addr_i <= lcd_drv_pkg::MEM_LAST &&
      (lcd_drv_pkg::MEM_LAST - cpu_addr_i) < 16'(NUM_SEG);
   // Segment zero at highest address
   assign mem_idx_w = 5'(lcd_drv_pkg::MEM_LAST - cpu_addr_i);
   assign cpu_hit_o = sel_supply_w | sel_mode_w | sel_mem_w;
   assign wr_any_w = cpu_wr_i | cpu_bit_wr_i;

   // Current contents of addressed location
   assign cur_w = sel_supply_w ? supply_r :
      sel_mode_w ? mode_r :
      sel_mem_w ? {4'h0, mem_r[mem_idx_w]} : 8'h00;

   // Byte write or single-bit manipulation on current value
   assign wval_w = cpu_bit_wr_i ?
      ((cur_w & ~(8'h01 << cpu_bit_sel_i)) |
       ({7'h00, cpu_wdata_i[0]} << cpu_bit_sel_i)) :
      cpu_wdata_i;
   // Only the ladder select bit is stored
   assign supply_nxt = (wr_any_w && sel_supply_w) ?
      {7'h00, wval_w[lcd_drv_pkg::SUPPLY_BIT]} : supply_r;
   assign mode_nxt = (wr_any_w && sel_mode_w) ? {wval_w[7:4], 4'h0} : mode_r;

   // Control registers
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         supply_r <= lcd_drv_pkg::SUPPLY_RST;
         mode_r <= lcd_drv_pkg::MODE_RST;
      end else begin
         supply_r <= supply_nxt;
         mode_r <= mode_nxt;
      end
   end

   // Display memory, low nibble only
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_SEG; i++) begin
            mem_r[i] <= 4'h0;
         end
      end else if (wr_any_w && sel_mem_w) begin
         mem_r[mem_idx_w] <= wval_w[3:0];
      end
   end

   // Read data register
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         cpu_rdata_o <= 8'h00;
      end else begin
         cpu_rdata_o <= cur_w;
      end
   end

   // Divider supply follows select bit
   assign ladder_supply_select_o = supply_r[lcd_drv_pkg::SUPPLY_BIT];

   // ------------------------------------------------------------
   // Scanning
   // ------------------------------------------------------------
   logic tick_w;
   logic on_w;
   logic [1:0] phase_r;
   logic pol_r;

   assign on_w = mode_r[lcd_drv_pkg::ON_BIT];

   lcd_scan_div #(
      .DIV_BASE(DIV_BASE)
   ) u_div (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .sel_i(mode_r[lcd_drv_pkg::CLKSEL_LSB +: 2]),
      .tick_o(tick_w)
   );

   // Phase counter and frame polarity
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         phase_r <= 2'h0;
         pol_r <= 1'b0;
      end else if (tick_w) begin
         phase_r <= phase_r + 2'h1;
         if (phase_r == 2'h3) begin
            pol_r <= ~pol_r;
         end
      end
   end

   assign phase_o = phase_r;
   assign polarity_o = pol_r;

   function automatic logic [1:0] level(input logic sel, input logic pol);
      // Common non-select sits two thirds from the select rail
      if (sel) begin
         level = pol ? lcd_drv_pkg::LVL_GND : lcd_drv_pkg::LVL_TOP;
      end else begin
         level = pol ? lcd_drv_pkg::LVL_TWO_THIRD : lcd_drv_pkg::LVL_THIRD;
      end
   endfunction

   function automatic logic [1:0] seg_level(input logic sel,
                                            input logic pol);
      // Segment is opposite rail to common
      if (sel) begin
         seg_level = pol ? lcd_drv_pkg::LVL_TOP : lcd_drv_pkg::LVL_GND;
      end else begin
         seg_level = pol ? lcd_drv_pkg::LVL_THIRD :
            lcd_drv_pkg::LVL_TWO_THIRD;
      end
   endfunction

   logic [2*lcd_drv_pkg::NUM_COM-1:0] com_nxt;
   logic [2*NUM_SEG-1:0] seg_nxt;

   // Output level encoding
   always_comb begin
      for (int c = 0; c < lcd_drv_pkg::NUM_COM; c++) begin
         com_nxt[2*c +: 2] = level(phase_r == 2'(c), pol_r);
      end
      for (int s = 0; s < NUM_SEG; s++) begin
         seg_nxt[2*s +: 2] = seg_level(on_w && mem_r[s][phase_r],
                                       pol_r);
      end
   end

   // Registered drive codes
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         common_outputs_o <= '0;
         segment_outputs_o <= '0;
      end else begin
         common_outputs_o <= com_nxt;
         segment_outputs_o <= seg_nxt;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   supply_reset_a: assert property (@(posedge clk_sys_i)
      !rst_n_i |=> supply_r == 8'h00)
      else $error("supply register not cleared");
   ladder_follow_a: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      (cpu_wr_i && !cpu_bit_wr_i && sel_supply_w) |=> ladder_supply_select_o ==
         $past(cpu_wdata_i[0]))
      else $error("ladder select wrong");
   bit_write_a: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      (cpu_bit_wr_i && !cpu_wr_i && sel_supply_w && cpu_bit_sel_i == 3'h0)
      |=> ladder_supply_select_o == $past(cpu_wdata_i[0]))
      else $error("bit write ignored");
   upper_zero_a: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      sel_mem_w |=> cpu_rdata_o[7:4] == 4'h0)
      else $error("upper nibble not zero");
   mem_reset_a: assert property (@(posedge clk_sys_i)
      !rst_n_i |=> mem_r[0] == 4'h0)
      else $error("memory not cleared");
   phase_step_a: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      tick_w |=> phase_r == $past(phase_r) + 2'h1)
      else $error("phase order wrong");
   frame_flip_a: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      (tick_w && phase_r == 2'h3) |=> pol_r != $past(pol_r))
      else $error("polarity not flipped");
   off_nonsel_a: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      ((rst_n_i && !on_w) ##1 !on_w) |-> segment_outputs_o[1:0] inside
         {lcd_drv_pkg::LVL_THIRD, lcd_drv_pkg::LVL_TWO_THIRD})
      else $error("segment selected while off");
endmodule

// File: rtl/lcd_drv_pkg.sv
// Constants for the segment/common panel driver
package lcd_drv_pkg;
   localparam logic [15:0] SUPPLY_ADDR = 16'hff92;
   localparam logic [15:0] MODE_ADDR = 16'hff90;
   localparam logic [15:0] MEM_FIRST = 16'hfa64;
   localparam logic [15:0] MEM_LAST = 16'hfa7f;
   localparam logic [7:0] SUPPLY_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam int SUPPLY_BIT = 0;
   localparam int ON_BIT = 7;
   localparam int CLKSEL_LSB = 4;
   localparam int DIV_BASE_LOG2 = 17;
   localparam int NUM_SEG = 28;
   localparam int NUM_COM = 4;
   // Ladder level codes: 0 = ground, 1 = one third, 2 = two thirds, 3 = top
   localparam logic [1:0] LVL_GND = 2'h0;
   localparam logic [1:0] LVL_THIRD = 2'h1;
   localparam logic [1:0] LVL_TWO_THIRD = 2'h2;
   localparam logic [1:0] LVL_TOP = 2'h3;
endpackage

// File: rtl/lcd_scan_div.sv
// Scan clock enable divider
module lcd_scan_div #(
   parameter int DIV_BASE = 17
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [1:0] sel_i,
   output logic tick_o
);
   initial begin
      if (DIV_BASE < 4 || DIV_BASE > 30) begin
         $error("lcd_scan_div: DIV_BASE out of range");
      end
   end

   logic [DIV_BASE-1:0] cnt_r;
   logic [DIV_BASE-1:0] cnt_nxt;
   logic [DIV_BASE-1:0] mask_w;

   // Count span shrinks by one bit per select code
   assign mask_w = {DIV_BASE{1'b1}} >> sel_i;
   assign cnt_nxt = (cnt_r & mask_w) == mask_w ? '0 : cnt_r + 1'b1;
   assign tick_o = (cnt_r & mask_w) == mask_w;

   // Free running counter
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// File: verif/lcd_panel_model.sv
// Passive four-backplane panel: flags pixels seeing full drive
module lcd_panel_model #(
   parameter int NUM_SEG = 28
) (
   input wire logic [7:0] com_i,
   input wire logic [2*NUM_SEG-1:0] seg_i,
   output logic [4*NUM_SEG-1:0] lit_o,
   output logic bias_err_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Lit only when common and segment sit on opposite outer levels
   // Every pixel must see an odd level step: one third or full drive
   always_comb begin
      bias_err_o = 1'b0;
      for (int c = 0; c < 4; c++) begin
         for (int s = 0; s < NUM_SEG; s++) begin
            bias_err_o = bias_err_o | (com_i[2*c] == seg_i[2*s]);
            lit_o[c*NUM_SEG+s] = {com_i[2*c+:2], seg_i[2*s+:2]} == 4'hc ||
               {com_i[2*c+:2], seg_i[2*s+:2]} == 4'h3;
         end
      end
   end
endmodule

// File: verif/test_lcd_segment_common_driver.sv
// Self-checking bench for the panel driver
module test_lcd_segment_common_driver;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NS = 28;
   logic clk_sys_i = 0;
   logic rst_n_i = 0;
   logic cpu_wr_i = 0;
   logic cpu_bit_wr_i = 0;
   logic [15:0] cpu_addr_i = 16'h0000;
   logic [2:0] cpu_bit_sel_i = 3'h0;
   logic [7:0] cpu_wdata_i = 8'h00;
   logic [7:0] cpu_rdata_o;
   logic cpu_hit_o;
   logic ladder_supply_select_o;
   logic polarity_o;
   logic [7:0] common_outputs_o;
   logic [2*NS-1:0] segment_outputs_o;
   logic [1:0] phase_o;
   logic [4*NS-1:0] lit;
   logic bias_err;
   logic [3:0] mem [NS];
   int error_cnt = 0;
   int checks_done = 0;
   always #2 clk_sys_i = ~clk_sys_i;
   lcd_segment_common_driver #(.NUM_SEG(NS), .DIV_BASE(4))
      lcd_segment_common_driver_inst (.clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i), .cpu_addr_i(cpu_addr_i), .cpu_wr_i(cpu_wr_i),
      .cpu_bit_wr_i(cpu_bit_wr_i), .cpu_bit_sel_i(cpu_bit_sel_i),
      .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o),
      .cpu_hit_o(cpu_hit_o), .ladder_supply_select_o(ladder_supply_select_o),
      .common_outputs_o(common_outputs_o),
      .segment_outputs_o(segment_outputs_o), .phase_o(phase_o),
      .polarity_o(polarity_o));
   lcd_panel_model #(.NUM_SEG(NS)) lcd_panel_model_inst (
      .com_i(common_outputs_o), .seg_i(segment_outputs_o), .lit_o(lit),
      .bias_err_o(bias_err));
   // ----------------------------------------
   // Access and check tasks
   // ----------------------------------------
   task chk(input string nm, input logic [127:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task final_report();
      if (error_cnt == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      cpu_addr_i <= a;
      cpu_wdata_i <= d;
      cpu_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      cpu_wr_i <= 1'b0;
   endtask
   task bw(input logic [15:0] a, input logic [2:0] b, input logic v);
      @(posedge clk_sys_i);
      cpu_addr_i <= a;
      cpu_bit_sel_i <= b;
      cpu_wdata_i <= {7'h00, v};
      cpu_bit_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      cpu_bit_wr_i <= 1'b0;
   endtask
   task rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk_sys_i);
      cpu_addr_i <= a;
      @(posedge clk_sys_i);
      #1;
      chk("rdata", cpu_rdata_o, e);
   endtask
   // Scan for a while, comparing drive codes with last cycle's phase
   task scan(input logic [1:0] sel, input logic on);
      logic [1:0] pp;
      logic ppol;
      int run;
      logic [7:0] ec;
      logic [2*NS-1:0] es;
      logic [4*NS-1:0] el;
      wr(16'hff90, {on, 1'b0, sel, 4'h0});
      rd(16'hff90, {on, 1'b0, sel, 4'h0});
      pp = phase_o;
      ppol = polarity_o;
      run = -100;
      repeat (80) begin
         @(posedge clk_sys_i);
         #1;
         for (int c = 0; c < 4; c++)
            ec[2*c+:2] = (c == pp) ? (ppol ? 2'h0 : 2'h3) :
               (ppol ? 2'h2 : 2'h1);
         for (int s = 0; s < NS; s++) begin
            es[2*s+:2] = (on && mem[s][pp]) ? (ppol ? 2'h3 : 2'h0) :
               (ppol ? 2'h1 : 2'h2);
            for (int c = 0; c < 4; c++)
               el[c*NS+s] = on && c == pp && mem[s][pp];
         end
         chk("com", common_outputs_o, ec);
         chk("seg", segment_outputs_o, es);
         chk("lit", lit, el);
         chk("bias", bias_err, 1'b0);
         run++;
         if (phase_o !== pp) begin
            chk("phase", {phase_o, polarity_o},
               {pp + 2'h1, ppol ^ (pp == 2'h3)});
            if (run > 0)
               chk("len", run, 16 >> sel);
            run = 0;
         end
         pp = phase_o;
         ppol = polarity_o;
      end
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd(16'hff92, 8'h00);
      chk("ladder", ladder_supply_select_o, 1'b0);
      rd(16'hfa64, 8'h00);
      chk("hit", cpu_hit_o, 1'b1);
      rd(16'hfa7f, 8'h00);
      // Bring-up order: memory, then supply, then scan clock
      for (int s = 0; s < NS; s++) begin
         mem[s] = 4'(s) ^ 4'h6;
         wr(16'(16'hfa7f - s), {4'hf, mem[s]});
      end
      for (int s = 0; s < NS; s++)
         rd(16'(16'hfa7f - s), {4'h0, mem[s]});
      rd(16'hfa63, 8'h00);
      chk("hit", cpu_hit_o, 1'b0);
      wr(16'hff92, 8'h81);
      rd(16'hff92, 8'h01);
      chk("ladder", ladder_supply_select_o, 1'b1);
      bw(16'hff92, 3'h0, 1'b0);
      rd(16'hff92, 8'h00);
      chk("ladder", ladder_supply_select_o, 1'b0);
      bw(16'hff92, 3'h0, 1'b1);
      rd(16'hff92, 8'h01);
      for (int k = 0; k < 4; k++)
         scan(2'(k), 1'b1);
      scan(2'h3, 1'b0);
      // Mid-run reset must clear written memory and supply bit
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd(16'hfa7f, 8'h00);
      rd(16'hff92, 8'h00);
      chk("ladder", ladder_supply_select_o, 1'b0);
      final_report();
   end
endmodule
